// ===== mfls_checker.sv
// Bus and control checks for the statistics counter bank.
// Assumes the bank's one-cycle Wishbone answer and control reset value.
`timescale 1ns/1ps
`include "mfls_consts.vh"
`default_nettype none
module mfls_checker (
   input wire clk_i,
   input wire rst_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [15:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   input wire [31:0] wb_dat_o,
   input wire wb_ack_o,
   input wire rx_enable_bit_o,
   input wire tx_enable_bit_o,
   input wire long_packet_enable_o,
   input wire pass_mac_control_frames_o,
   input wire [13:0] rx_max_length_limit_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Request decode and packed control outputs
   wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire wrc = wb_cyc_i & wb_stb_i & wb_we_i & (wb_adr_i == `MFLS_OFF_CTRL);
   wire [17:0] ctl = {rx_enable_bit_o, tx_enable_bit_o, long_packet_enable_o, pass_mac_control_frames_o,
      rx_max_length_limit_o};
   a_ack_follows: assert property (req |=> wb_ack_o) else $error("ack missing");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000) else $error("data not idle");
   a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 16'h4044 |->
      wb_dat_o == 32'h0000_0000) else $error("hole not zero");
   a_reset_ctrl: assert property ($past(rst_i) |-> ctl == {4'h0, `MFLS_LEN_MAX1})
      else $error("ctrl reset");
   a_rx_en_write: assert property (wb_ack_o && wrc && wb_sel_i[0] |=>
      rx_enable_bit_o == $past(wb_dat_i[`MFLS_CTRL_RX_EN])) else $error("rx enable");
   a_tx_en_write: assert property (wb_ack_o && wrc && wb_sel_i[0] |=>
      tx_enable_bit_o == $past(wb_dat_i[`MFLS_CTRL_TX_EN])) else $error("tx enable");
   a_mode_write: assert property (wb_ack_o && wrc && wb_sel_i[0] |=> {pass_mac_control_frames_o,
      long_packet_enable_o} == $past(wb_dat_i[3:2])) else $error("mode bits");
   a_maxlen_write: assert property (wb_ack_o && wrc && wb_sel_i[2] && wb_sel_i[3] |=>
      rx_max_length_limit_o == $past(wb_dat_i[29:16])) else $error("max length");
   a_ctrl_hold: assert property (!wrc && !$past(wrc) |-> $stable(ctl)) else $error("ctrl moved");
   // Main scenarios
   c_read: cover property (wb_ack_o && !wb_we_i);
   c_ctrl_write: cover property (wb_ack_o && wrc);
   c_lpe_on: cover property ($rose(long_packet_enable_o));
endmodule // mfls_checker
bind mfls_counters mfls_checker i_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
   .wb_dat_i, .wb_dat_o, .wb_ack_o, .rx_enable_bit_o, .tx_enable_bit_o, .long_packet_enable_o,
   .pass_mac_control_frames_o, .rx_max_length_limit_o);
`default_nettype wire

// ===== mfls_consts.vh
// Constants for the flow, length and size statistics counter bank.
// Assumes a 32-bit classic Wishbone slave on a 50 MHz core clock.
// Function
// - Count every host packet the MAC drops
// - Length error on filtered packet under 64
// - Oversize above 1518/1522/1526 by VLAN tags
// - Long packets: oversize above programmed maximum length
// - Length counts destination address through CRC
// - Runts under 25 bytes may go uncounted
// - Receive counters hold while receive disabled
// - Count valid received resume frames, either address
// - Count valid received pause frames, either address
// - Count every transmitted resume frame
// - Count every transmitted pause frame
// - Transmit pause counters need transmit enable
// - Count matched control frames with bad opcode
// - Pass-control mode counts filter failures too
// - Minimum bin counts good 64-byte packets only
// - One bin per good packet, 65 to 1023
// - Exclude control frames and missed packets
// - 32-bit counters, zero at reset, clear on read
// - Events visible within one microsecond
`ifndef MFLS_CONSTS_VH
`define MFLS_CONSTS_VH

// Counter offsets (byte addresses)
`define MFLS_OFF_HTX_DISCARD 16'h403C
`define MFLS_OFF_RX_LEN_ERR 16'h4040
`define MFLS_OFF_RESUME_RX 16'h4048
`define MFLS_OFF_RESUME_TX 16'h404C
`define MFLS_OFF_PAUSE_RX 16'h4050
`define MFLS_OFF_PAUSE_TX 16'h4054
`define MFLS_OFF_UNSUP_CTRL 16'h4058
`define MFLS_OFF_BIN_MIN 16'h405C
`define MFLS_OFF_BIN_SMALL 16'h4060
`define MFLS_OFF_BIN_MEDIUM 16'h4064
`define MFLS_OFF_BIN_LARGE 16'h4068
`define MFLS_OFF_BIN_XLARGE 16'h406C
// Control and status registers
`define MFLS_OFF_CTRL 16'h4100
`define MFLS_OFF_STATUS 16'h4104

// Control register fields
`define MFLS_CTRL_RX_EN 0
`define MFLS_CTRL_TX_EN 1
`define MFLS_CTRL_LPE 2
`define MFLS_CTRL_PMCF 3
`define MFLS_CTRL_MAXLEN_LSB 16
`define MFLS_CTRL_MAXLEN_MSB 29
`define MFLS_CTRL_RESET 32'h05F2_0000

// Counter reset value and count
`define MFLS_CNT_RESET 32'h0000_0000
`define MFLS_NUM_CNT 12

// Length limits in bytes
`define MFLS_LEN_MIN 14'h0040
`define MFLS_LEN_RUNT 14'h0019
`define MFLS_LEN_MAX0 14'h05EE
`define MFLS_LEN_MAX1 14'h05F2
`define MFLS_LEN_MAX2 14'h05F6
`define MFLS_LEN_BIN1 14'h007F
`define MFLS_LEN_BIN2 14'h00FF
`define MFLS_LEN_BIN3 14'h01FF
`define MFLS_LEN_BIN4 14'h03FF

// Visibility time and clock rate
`define MFLS_VIS_NS 1000
`define MFLS_CLK_NS 20
`define MFLS_VIS_CYC (`MFLS_VIS_NS / `MFLS_CLK_NS)

`endif

// ===== mfls_counters.v
// Statistics counter bank: host transmit discards, receive length errors,
// pause/resume frames and the receive size histogram up to 1023 bytes.
// Assumes same-clock event pulses from the MAC paths and a Wishbone master.
`timescale 1ns/1ps
`include "mfls_consts.vh"
`default_nettype none

module mfls_counters (
   input wire clk_i,
   input wire rst_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [15:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   input wire tx_discard_i,
   input wire rx_done_i,
   input wire [13:0] rx_len_i,
   input wire [1:0] rx_vlan_tags_i,
   input wire rx_filter_pass_i,
   input wire rx_good_i,
   input wire rx_missed_i,
   input wire rx_is_fc_i,
   input wire rx_fc_addr_match_i,
   input wire rx_fc_type_match_i,
   input wire rx_resume_op_i,
   input wire rx_pause_op_i,
   input wire tx_resume_sent_i,
   input wire tx_pause_sent_i,
   output reg rx_enable_bit_o,
   output reg tx_enable_bit_o,
   output reg long_packet_enable_o,
   output reg pass_mac_control_frames_o,
   output reg [13:0] rx_max_length_limit_o
);

   // Counter indices
   localparam [3:0] C_HTX = 4'h0;
   localparam [3:0] C_LEN = 4'h1;
   localparam [3:0] C_RRX = 4'h2;
   localparam [3:0] C_RTX = 4'h3;
   localparam [3:0] C_PRX = 4'h4;
   localparam [3:0] C_PTX = 4'h5;
   localparam [3:0] C_UNS = 4'h6;
   localparam [3:0] C_B64 = 4'h7;
   localparam [3:0] C_NONE = 4'hF;
   // Control reset image, sliced for the length field
   localparam [31:0] CTRL_RST = `MFLS_CTRL_RESET;

   // Address to counter index decode
   function [3:0] cnt_index;
      input [15:0] adr;
      begin
         case (adr)
            `MFLS_OFF_HTX_DISCARD: cnt_index = 4'h0;
            `MFLS_OFF_RX_LEN_ERR: cnt_index = 4'h1;
            `MFLS_OFF_RESUME_RX: cnt_index = 4'h2;
            `MFLS_OFF_RESUME_TX: cnt_index = 4'h3;
            `MFLS_OFF_PAUSE_RX: cnt_index = 4'h4;
            `MFLS_OFF_PAUSE_TX: cnt_index = 4'h5;
            `MFLS_OFF_UNSUP_CTRL: cnt_index = 4'h6;
            `MFLS_OFF_BIN_MIN: cnt_index = 4'h7;
            `MFLS_OFF_BIN_SMALL: cnt_index = 4'h8;
            `MFLS_OFF_BIN_MEDIUM: cnt_index = 4'h9;
            `MFLS_OFF_BIN_LARGE: cnt_index = 4'hA;
            `MFLS_OFF_BIN_XLARGE: cnt_index = 4'hB;
            default: cnt_index = C_NONE;
         endcase
      end
   endfunction

   reg [31:0] cnt_q [0:`MFLS_NUM_CNT-1];
   reg [`MFLS_NUM_CNT-1:0] ev_q;
   reg [`MFLS_NUM_CNT-1:0] ev_d;
   reg [`MFLS_NUM_CNT-1:0] clr_d;
   reg [3:0] idx_d;
   reg [13:0] len_max_d;
   reg oversize_d;
   reg undersize_d;
   reg hist_ok_d;
   wire bus_req;
   wire rd_cnt;

   assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign rd_cnt = bus_req & ~wb_we_i;

   // Oversize threshold from tag count or programmed limit
   always @* begin
      if (long_packet_enable_o) begin
         len_max_d = rx_max_length_limit_o;
      end else begin
         case (rx_vlan_tags_i)
            2'd0: len_max_d = `MFLS_LEN_MAX0;
            2'd1: len_max_d = `MFLS_LEN_MAX1;
            default: len_max_d = `MFLS_LEN_MAX2;
         endcase
      end
   end

   // Event decode; lengths are DA through CRC as given by the MAC
   always @* begin
      ev_d = {`MFLS_NUM_CNT{1'b0}};
      // Runts under 25 bytes are skipped on purpose
      undersize_d = (rx_len_i < `MFLS_LEN_MIN) && (rx_len_i >= `MFLS_LEN_RUNT);
      oversize_d = rx_len_i > len_max_d;
      hist_ok_d = rx_done_i & rx_enable_bit_o & rx_good_i & rx_filter_pass_i
                  & ~rx_is_fc_i & ~rx_missed_i;
      ev_d[C_HTX] = tx_discard_i;
      ev_d[C_LEN] = rx_done_i & rx_enable_bit_o & rx_filter_pass_i
                    & (undersize_d | oversize_d);
      ev_d[C_RRX] = rx_done_i & rx_enable_bit_o & rx_good_i & rx_is_fc_i
                    & rx_fc_addr_match_i & rx_fc_type_match_i & rx_resume_op_i;
      ev_d[C_PRX] = rx_done_i & rx_enable_bit_o & rx_good_i & rx_is_fc_i
                    & rx_fc_addr_match_i & rx_fc_type_match_i & rx_pause_op_i;
      ev_d[C_RTX] = tx_resume_sent_i & tx_enable_bit_o;
      ev_d[C_PTX] = tx_pause_sent_i & tx_enable_bit_o;
      ev_d[C_UNS] = rx_done_i & rx_enable_bit_o & rx_fc_type_match_i
                    & ~rx_resume_op_i & ~rx_pause_op_i
                    & (rx_fc_addr_match_i | pass_mac_control_frames_o);
      ev_d[C_B64] = hist_ok_d & (rx_len_i == `MFLS_LEN_MIN);
      ev_d[8] = hist_ok_d & (rx_len_i > `MFLS_LEN_MIN) & (rx_len_i <= `MFLS_LEN_BIN1);
      ev_d[9] = hist_ok_d & (rx_len_i > `MFLS_LEN_BIN1) & (rx_len_i <= `MFLS_LEN_BIN2);
      ev_d[10] = hist_ok_d & (rx_len_i > `MFLS_LEN_BIN2) & (rx_len_i <= `MFLS_LEN_BIN3);
      ev_d[11] = hist_ok_d & (rx_len_i > `MFLS_LEN_BIN3) & (rx_len_i <= `MFLS_LEN_BIN4);
   end

   // Register the events once, well inside the visibility window
   always @(posedge clk_i) begin
      if (rst_i) begin
         ev_q <= {`MFLS_NUM_CNT{1'b0}};
      end else begin
         ev_q <= ev_d;
      end
   end

   // Which counter a read clears this cycle
   always @* begin
      idx_d = cnt_index(wb_adr_i);
      clr_d = {`MFLS_NUM_CNT{1'b0}};
      if (rd_cnt && idx_d != C_NONE) begin
         clr_d[idx_d] = 1'b1;
      end
   end

   // Counter array: clear on read, increment survives the clear
   genvar gi;
   generate
      for (gi = 0; gi < `MFLS_NUM_CNT; gi = gi + 1) begin : g_cnt
         always @(posedge clk_i) begin
            if (rst_i) begin
               cnt_q[gi] <= `MFLS_CNT_RESET;
            end else if (clr_d[gi]) begin
               cnt_q[gi] <= {31'h0000_0000, ev_q[gi]};
            end else if (ev_q[gi]) begin
               cnt_q[gi] <= cnt_q[gi] + 32'h0000_0001;
            end
         end
      end
   endgenerate

   // Control register with byte-lane writes
   always @(posedge clk_i) begin
      if (rst_i) begin
         rx_enable_bit_o <= 1'b0;
         tx_enable_bit_o <= 1'b0;
         long_packet_enable_o <= 1'b0;
         pass_mac_control_frames_o <= 1'b0;
         rx_max_length_limit_o <= CTRL_RST[`MFLS_CTRL_MAXLEN_MSB:`MFLS_CTRL_MAXLEN_LSB];
      end else if (bus_req && wb_we_i && wb_adr_i == `MFLS_OFF_CTRL) begin
         if (wb_sel_i[0]) begin
            rx_enable_bit_o <= wb_dat_i[`MFLS_CTRL_RX_EN];
            tx_enable_bit_o <= wb_dat_i[`MFLS_CTRL_TX_EN];
            long_packet_enable_o <= wb_dat_i[`MFLS_CTRL_LPE];
            pass_mac_control_frames_o <= wb_dat_i[`MFLS_CTRL_PMCF];
         end
         if (wb_sel_i[2]) begin
            rx_max_length_limit_o[7:0] <= wb_dat_i[23:16];
         end
         if (wb_sel_i[3]) begin
            rx_max_length_limit_o[13:8] <= wb_dat_i[29:24];
         end
      end
   end

   // Bus answer: one-cycle ack, unmapped reads return zero
   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= bus_req;
         wb_dat_o <= 32'h0000_0000;
         if (rd_cnt) begin
            if (idx_d != C_NONE) begin
               wb_dat_o <= cnt_q[idx_d];
            end else if (wb_adr_i == `MFLS_OFF_CTRL) begin
               wb_dat_o <= {2'b00, rx_max_length_limit_o, 12'h000, pass_mac_control_frames_o,
                            long_packet_enable_o, tx_enable_bit_o, rx_enable_bit_o};
            end else if (wb_adr_i == `MFLS_OFF_STATUS) begin
               wb_dat_o <= {20'h00000, ev_q};
            end
         end
      end
   end

endmodule // mfls_counters
`default_nettype wire

// ===== mfls_counters_test.sv
// Self-checking bench for the statistics counter bank.
// Assumes a one-cycle Wishbone answer and counts visible two edges on.
`timescale 1ns/1ps
`include "mfls_consts.vh"
`default_nettype none
module mfls_counters_test;
   logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, rx_done_i = 1'b0;
   logic [15:0] wb_adr_i = 16'h0000;
   logic [3:0] wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, ev, ex [12], q [$];
   logic wb_ack_o;
   logic [13:0] rx_len_i = 14'h0000, ln;
   logic [1:0] rx_vlan_tags_i = 2'h0;
   logic [7:0] fl = 8'h00;
   logic [2:0] tv = 3'h0;
   int i, b, seed = 44, miscompares = 0, cmp_count = 0, cyc_n = 0;
   wire rx_filter_pass_i, rx_good_i, rx_missed_i, rx_is_fc_i, rx_fc_addr_match_i, rx_fc_type_match_i;
   wire rx_resume_op_i, rx_pause_op_i, tx_discard_i, tx_resume_sent_i, tx_pause_sent_i;
   localparam logic [15:0] OFF [12] = '{`MFLS_OFF_HTX_DISCARD, `MFLS_OFF_RX_LEN_ERR, `MFLS_OFF_RESUME_RX,
      `MFLS_OFF_RESUME_TX, `MFLS_OFF_PAUSE_RX, `MFLS_OFF_PAUSE_TX, `MFLS_OFF_UNSUP_CTRL, `MFLS_OFF_BIN_MIN,
      `MFLS_OFF_BIN_SMALL, `MFLS_OFF_BIN_MEDIUM, `MFLS_OFF_BIN_LARGE, `MFLS_OFF_BIN_XLARGE};
   // Packets: length, tag count, flags, counter index (F for none)
   localparam logic [31:0] T [30] = '{32'h0040_0C07, 32'h0040_0D0F, 32'h0040_0E0F, 32'h0040_080F,
      32'h003F_0801, 32'h003F_000F, 32'h05EF_0801, 32'h05EE_080F, 32'h05F2_180F, 32'h05F3_1801,
      32'h05F6_280F, 32'h05F7_2801, 32'h0040_0DE2, 32'h0040_0DD4, 32'h0040_0DC6, 32'h0040_0D4F,
      32'h0041_0C08, 32'h007F_0C08, 32'h0080_0C09, 32'h00FF_0C09, 32'h0100_0C0A, 32'h01FF_0C0A,
      32'h0200_0C0B, 32'h03FF_0C0B, 32'h0101_0801, 32'h0100_080F, 32'h0040_0D46,
      32'h0040_0C0F, 32'h003F_080F, 32'h0040_0DEF};
   assign {rx_filter_pass_i, rx_good_i, rx_missed_i, rx_is_fc_i, rx_fc_addr_match_i, rx_fc_type_match_i,
      rx_resume_op_i, rx_pause_op_i} = fl;
   assign {tx_discard_i, tx_resume_sent_i, tx_pause_sent_i} = tv;
   mfls_counters i_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
      .wb_dat_o, .wb_ack_o, .tx_discard_i, .rx_done_i, .rx_len_i, .rx_vlan_tags_i, .rx_filter_pass_i,
      .rx_good_i, .rx_missed_i, .rx_is_fc_i, .rx_fc_addr_match_i, .rx_fc_type_match_i, .rx_resume_op_i,
      .rx_pause_op_i, .tx_resume_sent_i, .tx_pause_sent_i, .rx_enable_bit_o(), .tx_enable_bit_o(),
      .long_packet_enable_o(), .pass_mac_control_frames_o(), .rx_max_length_limit_o());
   // Clock
   always #10 clk_i = ~clk_i;
   task automatic print_verdict();
      $display("Compares %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // Single classic cycle, held until ack is sampled
   task automatic wb(input logic we, input logic [15:0] a, input logic [31:0] d);
      @(posedge clk_i);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1) @(posedge clk_i);
      {wb_cyc_i, wb_stb_i} <= 2'b00;
   endtask
   task automatic rda(input logic [15:0] a, input logic [31:0] e);
      q.push_back(e);
      wb(1'b0, a, 32'h0000_0000);
   endtask
   // Read every counter, then expect it cleared
   task automatic chk();
      for (int k = 0; k < 12; k++) begin
         rda(OFF[k], ex[k]);
         ex[k] = 32'h0000_0000;
      end
   endtask
   task automatic rx(input logic [13:0] l, input logic [1:0] v, input logic [7:0] f);
      @(posedge clk_i);
      {rx_done_i, rx_len_i, rx_vlan_tags_i, fl} <= {1'b1, l, v, f};
      @(posedge clk_i);
      rx_done_i <= 1'b0;
   endtask
   task automatic sends(input int a, input int z);
      for (int j = a; j <= z; j++) begin
         rx(T[j][29:16], T[j][13:12], T[j][11:4]);
         if (T[j][3:0] != 4'hF) ex[T[j][3:0]]++;
      end
   endtask
   task automatic tx(input logic [2:0] t);
      @(posedge clk_i);
      tv <= t;
      @(posedge clk_i);
      tv <= 3'h0;
   endtask
   // Compare each read answer with the oldest note; cut hangs short
   always @(posedge clk_i) begin
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
         ev = q.pop_front();
         cmp_count++;
         if (wb_dat_o !== ev) begin
            miscompares++;
            $display("Error t=%0t got %h exp %h", $time, wb_dat_o, ev);
         end
      end
      cyc_n++;
      if (cyc_n == 20000) begin
         miscompares++;
         print_verdict();
      end
   end
   // Main sequence
   initial begin
      for (i = 0; i < 12; i++) ex[i] = 32'h0000_0000;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      rda(`MFLS_OFF_CTRL, `MFLS_CTRL_RESET);
      rda(16'h4044, 32'h0000_0000);
      rda(`MFLS_OFF_STATUS, 32'h0000_0000);
      chk();
      wb(1'b1, `MFLS_OFF_CTRL, 32'h05F2_0003);
      rda(`MFLS_OFF_CTRL, 32'h05F2_0003);
      sends(0, 23);
      for (b = 0; b < 4; b++) begin
         ln = 14'(64 << b) + 14'($unsigned($random(seed)) % (64 << b));
         rx(ln, 2'd0, 8'hC0);
         ex[ln == 14'd64 ? 7 : 8 + b]++;
      end
      chk();
      wb(1'b1, `MFLS_OFF_CTRL, 32'h0100_000F);
      sends(24, 26);
      chk();
      wb(1'b1, `MFLS_OFF_CTRL, 32'h0100_000E);
      sends(27, 29);
      for (i = 0; i < 2; i++) begin
         tx(3'b111);
         ex[0]++;
         ex[3]++;
         ex[5]++;
      end
      wb(1'b1, `MFLS_OFF_CTRL, 32'h0100_0001);
      tx(3'b111);
      ex[0]++;
      // Discard registers in the very edge whose read clears its counter
      fork
         tx(3'b100);
         begin
            @(posedge clk_i);
            rda(`MFLS_OFF_HTX_DISCARD, ex[0]);
         end
      join
      ex[0] = 32'h0000_0001;
      chk();
      print_verdict();
   end
endmodule // mfls_counters_test
`default_nettype wire
